// ### dv/epp_periph_model.sv
// behavioural epp peripheral answering read cycles
`timescale 1ns/100ps
module epp_periph_model (
  input wire logic clock,
  input wire logic data_strobe_n,
  input wire logic addr_strobe_n,
  input wire logic [7:0] rdata,
  input wire logic [7:0] dly,
  output logic [7:0] pd_in,
  output logic peripheral_wait_n
);
  logic [7:0] cnt = 8'h00;
  initial pd_in = 8'h5A;
  initial peripheral_wait_n = 1'b0;
  // released bus toggles each cycle so a late sample cannot match by luck
  always @(posedge clock)
  begin
    if (!data_strobe_n || !addr_strobe_n)
    begin
      if (cnt != 8'hFF) cnt <= cnt + 8'h01;
      if (cnt == dly) pd_in <= rdata;
      if (cnt > dly) peripheral_wait_n <= 1'b1;
    end
    else
    begin
      cnt <= 8'h00;
      pd_in <= ~pd_in;
      peripheral_wait_n <= 1'b0;
    end
  end
endmodule

// ### dv/testbench.sv
// self-checking bench for the epp read-cycle port
`timescale 1ns/100ps
module testbench;
  typedef struct {logic a; logic [7:0] d; logic [7:0] dl;} row_t;
  logic clock = 1'b0, nrst = 1'b0, host_read = 1'b0, host_sel_addr = 1'b0;
  logic control_direction_bit = 1'b0, control_write_override = 1'b0;
  logic reset_request = 1'b0, timeout_clear = 1'b0, peripheral_interrupt = 1'b0;
  logic ce = 1'b1;
  logic peripheral_wait_n, pd_oe_n, iochrdy, data_strobe_n, addr_strobe_n;
  logic write_indicator_n, port_direction, peripheral_reset_n, host_interrupt;
  logic timeout_status;
  logic [7:0] pd_in, pd_out, host_rdata, pdat = 8'h00, dly = 8'h04;
  int fail_count = 0, n_checks = 0;
  row_t rows [4] = '{'{1'b0, 8'hA5, 8'h04}, '{1'b1, 8'h3C, 8'h06},
                     '{1'b0, 8'hFF, 8'h04}, '{1'b1, 8'h00, 8'h09}};
  // short watchdog count keeps the abort case to a few dozen cycles
  epp_read_cycle_port #(.W(8), .TIMEOUT_CYCLES(20)) u_dut (.clock(clock), .nrst(nrst),
    .ce(ce), .host_read(host_read), .host_sel_addr(host_sel_addr),
    .control_direction_bit(control_direction_bit),
    .control_write_override(control_write_override), .reset_request(reset_request),
    .timeout_clear(timeout_clear), .peripheral_wait_n(peripheral_wait_n),
    .peripheral_interrupt(peripheral_interrupt), .pd_in(pd_in), .pd_out(pd_out),
    .pd_oe_n(pd_oe_n), .host_rdata(host_rdata), .iochrdy(iochrdy),
    .data_strobe_n(data_strobe_n), .addr_strobe_n(addr_strobe_n),
    .write_indicator_n(write_indicator_n), .port_direction(port_direction),
    .peripheral_reset_n(peripheral_reset_n), .host_interrupt(host_interrupt),
    .timeout_status(timeout_status));
  epp_periph_model u_periph (.clock(clock), .data_strobe_n(data_strobe_n),
    .addr_strobe_n(addr_strobe_n), .rdata(pdat), .dly(dly), .pd_in(pd_in),
    .peripheral_wait_n(peripheral_wait_n));
  initial
  begin
    forever #2 clock = ~clock;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one host read; entered and left just after a rising edge
  task automatic rd(input logic a, input logic [7:0] d, input logic [7:0] dl, input logic to);
    int n;
    host_sel_addr <= a;
    pdat <= d;
    dly <= dl;
    host_read <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("sel_strobe", a ? addr_strobe_n : data_strobe_n, 8'h00);
    chk("idle_strobe", a ? data_strobe_n : addr_strobe_n, 8'h01);
    chk("dir_read", port_direction, 8'h01);
    chk("wr_ind", write_indicator_n, 8'h01);
    chk("rdy_low", iochrdy, 8'h00);
    n = 0;
    while (iochrdy !== 1'b1 && n < 60)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("rdy_high", iochrdy, 8'h01);
    chk("to_stat", timeout_status, to);
    if (!to) chk("rdata", host_rdata, d);
    @(posedge clock);
    host_read <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("strobes_off", {data_strobe_n, addr_strobe_n}, 8'h03);
    chk("dir_back", port_direction, 8'h00);
    chk("bus_off", pd_oe_n, 8'h01);
    chk("bus_out", pd_out, 8'h00);
    $display("test read done");
    @(posedge clock);
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    #1;
    chk("rst_out", {peripheral_reset_n, iochrdy, data_strobe_n, addr_strobe_n}, 8'h07);
    $display("test power-on done");
    @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (rows[i]) rd(rows[i].a, rows[i].d, rows[i].dl, 1'b0);
    rd(1'b0, 8'h81, 8'hC8, 1'b1);
    timeout_clear <= 1'b1;
    @(posedge clock);
    timeout_clear <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("to_clr", timeout_status, 8'h00);
    peripheral_interrupt <= 1'b1;
    control_write_override <= 1'b1;
    control_direction_bit <= 1'b1;
    reset_request <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("peripheral_interrupt", host_interrupt, 8'h01);
    chk("override", write_indicator_n, 8'h00);
    chk("dir_bit", port_direction, 8'h01);
    chk("prst", peripheral_reset_n, 8'h00);
    @(posedge clock);
    {peripheral_interrupt, control_write_override, control_direction_bit} <= 3'h0;
    reset_request <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk("released", {host_interrupt, write_indicator_n, peripheral_reset_n}, 8'h03);
    $display("test controls done");
    // frozen clock enable: a pending read must not start a cycle
    @(posedge clock);
    ce <= 1'b0;
    host_read <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("ce_hold", {data_strobe_n, addr_strobe_n, iochrdy}, 8'h07);
    @(posedge clock);
    host_read <= 1'b0;
    ce <= 1'b1;
    $display("test enable done");
    // reset in mid-cycle: strobe drops at once, port restarts clean
    @(posedge clock);
    host_sel_addr <= 1'b0;
    dly <= 8'hC8;
    host_read <= 1'b1;
    repeat (3) @(posedge clock);
    nrst <= 1'b0;
    host_read <= 1'b0;
    #1;
    chk("rst_mid", {peripheral_reset_n, iochrdy, data_strobe_n, addr_strobe_n}, 8'h07);
    chk("rst_rdata", host_rdata, 8'h00);
    @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    chk("rst_rel", {peripheral_reset_n, iochrdy, port_direction}, 8'h06);
    $display("test reset done");
    finish_test();
  end
  // cuts a hang short well after the expected run of about 125 cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    fail_count++;
    finish_test();
  end
endmodule

// ### rtl/epp_capture_reg.sv
// byte-wide capture register with load enable and clock enable
`timescale 1ns/100ps
module epp_capture_reg #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // hold unless loading
  always_comb
  begin
    q_nxt = q_r;
    if (load)
      q_nxt = d;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      q_r <= '0;
    else if (ce)
      q_r <= q_nxt;
  end

  assign q = q_r;
endmodule

// ### rtl/epp_port_pkg.sv
// shared constants for the epp 1.7 read-cycle port
package epp_port_pkg;
  localparam int WORD_W = 8;
  localparam int CLK_MHZ = 250;
  localparam int TIMEOUT_US = 10;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int RESET_CYC = 4;
  localparam int TO_STATUS_BIT = 0;
  localparam logic [7:0] DATA_RST = 8'h00;
endpackage

// ### rtl/epp_read_cycle_port.sv
// epp 1.7 read-cycle port: host strobes in, epp pins out
`timescale 1ns/100ps
module epp_read_cycle_port #(
  parameter int W = epp_port_pkg::WORD_W,
  parameter int TIMEOUT_CYCLES = epp_port_pkg::TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic host_read,
  input wire logic host_sel_addr,
  input wire logic control_direction_bit,
  input wire logic control_write_override,
  input wire logic reset_request,
  input wire logic timeout_clear,
  input wire logic peripheral_wait_n,
  input wire logic peripheral_interrupt,
  input wire logic [W-1:0] pd_in,
  output logic [W-1:0] pd_out,
  output logic pd_oe_n,
  output logic [W-1:0] host_rdata,
  output logic iochrdy,
  output logic data_strobe_n,
  output logic addr_strobe_n,
  output logic write_indicator_n,
  output logic port_direction,
  output logic peripheral_reset_n,
  output logic host_interrupt,
  output logic timeout_status
);
  typedef enum logic [1:0] {IDLE, STROBE, DONE} state_t;
  localparam int TCW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TCW-1:0] TC_MAX = TCW'(TIMEOUT_CYCLES);

  state_t state_r, state_nxt;
  logic [TCW-1:0] tcnt_r, tcnt_nxt;
  logic dstb_r, dstb_nxt, astb_r, astb_nxt;
  logic rdy_r, rdy_nxt, dir_r, dir_nxt, wrn_r, wrn_nxt;
  logic to_r, to_nxt, rstn_r, rstn_nxt, peripheral_interrupt_r;
  logic [2:0] rcnt_r, rcnt_nxt;
  logic cap_load;
  logic [W-1:0] cap_q;
  logic expired;

  assign expired = (tcnt_r == TC_MAX);

  // cycle sequencer: strobe on read, release ready on wait or watchdog
  always_comb
  begin
    state_nxt = state_r;
    tcnt_nxt = tcnt_r;
    dstb_nxt = dstb_r;
    astb_nxt = astb_r;
    rdy_nxt = rdy_r;
    to_nxt = to_r;
    cap_load = 1'b0;
    if (timeout_clear)
      to_nxt = 1'b0;
    case (state_r)
      IDLE:
      begin
        rdy_nxt = 1'b1;
        tcnt_nxt = '0;
        if (host_read)
        begin
          state_nxt = STROBE;
          dstb_nxt = ~host_sel_addr;
          astb_nxt = host_sel_addr;
          rdy_nxt = 1'b0;
        end
      end
      STROBE:
      begin
        if (!expired)
          tcnt_nxt = tcnt_r + TCW'(1);
        // ready follows the released wait one cycle late, on the same edge that latches the byte
        rdy_nxt = peripheral_wait_n;
        if (peripheral_wait_n)
          cap_load = 1'b1;
        if (expired)
        begin
          rdy_nxt = 1'b1;
          to_nxt = 1'b1; // set beats clear
          dstb_nxt = 1'b0;
          astb_nxt = 1'b0;
          state_nxt = DONE; // abort
        end
        if (!host_read)
        begin
          dstb_nxt = 1'b0;
          astb_nxt = 1'b0;
          rdy_nxt = 1'b1;
          state_nxt = IDLE;
        end
      end
      DONE:
      begin
        rdy_nxt = 1'b1;
        if (!host_read)
          state_nxt = IDLE; // peripheral floats once strobe is gone
      end
      default:
        state_nxt = IDLE;
    endcase
  end

  // pin shaping: direction, write indicator, peripheral reset
  always_comb
  begin
    dir_nxt = control_direction_bit || (state_nxt == STROBE);
    wrn_nxt = 1'b1;
    if (control_write_override)
      wrn_nxt = 1'b0; // only override allowed
    rcnt_nxt = rcnt_r;
    rstn_nxt = 1'b1;
    if (reset_request)
      rcnt_nxt = 3'(epp_port_pkg::RESET_CYC);
    else if (rcnt_r != 3'h0)
      rcnt_nxt = rcnt_r - 3'h1;
    if (reset_request || rcnt_r != 3'h0)
      rstn_nxt = 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= IDLE;
      tcnt_r <= '0;
      dstb_r <= 1'b0;
      astb_r <= 1'b0;
      rdy_r <= 1'b1;
      to_r <= 1'b0;
      dir_r <= 1'b0;
      wrn_r <= 1'b1;
      rcnt_r <= 3'h0;
      rstn_r <= 1'b0;
      peripheral_interrupt_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      tcnt_r <= tcnt_nxt;
      dstb_r <= dstb_nxt;
      astb_r <= astb_nxt;
      rdy_r <= rdy_nxt;
      to_r <= to_nxt;
      dir_r <= dir_nxt;
      wrn_r <= wrn_nxt;
      rcnt_r <= rcnt_nxt;
      rstn_r <= rstn_nxt;
      peripheral_interrupt_r <= peripheral_interrupt; // no inversion
    end
  end

  // read data latch, loaded in STROBE while wait is released
  epp_capture_reg #(
    .W(W)
  ) u_cap (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .load(cap_load),
    .d(pd_in),
    .q(cap_q)
  );

  // read-only port: the bus is never driven, so the enable stays high
  assign pd_out = epp_port_pkg::DATA_RST;
  assign pd_oe_n = 1'b1;
  assign host_rdata = cap_q;
  assign iochrdy = rdy_r;
  assign data_strobe_n = ~dstb_r;
  assign addr_strobe_n = ~astb_r;
  assign write_indicator_n = wrn_r;
  assign port_direction = dir_r;
  assign peripheral_reset_n = rstn_r;
  assign host_interrupt = peripheral_interrupt_r;
  assign timeout_status = to_r;

  property p_strobe_on_read;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == IDLE && host_read) |=> (data_strobe_n ^ addr_strobe_n);
  endproperty
  a_strobe_on_read: assert property (p_strobe_on_read)
    else $error("no strobe after read start");

  property p_ready_held;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == STROBE && host_read && !peripheral_wait_n && !expired) |=> !iochrdy;
  endproperty
  a_ready_held: assert property (p_ready_held)
    else $error("ready released during wait");

  property p_strobe_drop;
    @(posedge clock) disable iff (!nrst)
    (ce && !host_read && state_r == STROBE) |=> (data_strobe_n && addr_strobe_n && iochrdy);
  endproperty
  a_strobe_drop: assert property (p_strobe_drop)
    else $error("strobe kept after host release");

  property p_dir;
    @(posedge clock) disable iff (!nrst)
    (!data_strobe_n || !addr_strobe_n) |-> port_direction;
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction low during read");

  property p_timeout;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == STROBE && host_read && expired) |=> timeout_status && iochrdy;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("watchdog did not abort");

  property p_capture;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == STROBE && peripheral_wait_n) |=> (host_rdata == $past(pd_in));
  endproperty
  a_capture: assert property (p_capture)
    else $error("read data not captured");

  property p_peripheral_interrupt;
    @(posedge clock) disable iff (!nrst)
    ce |=> (host_interrupt == $past(peripheral_interrupt));
  endproperty
  a_peripheral_interrupt: assert property (p_peripheral_interrupt)
    else $error("interrupt altered");

  property p_wr;
    @(posedge clock) disable iff (!nrst)
    (ce && !control_write_override) |=> write_indicator_n;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write indicator asserted without override");

  property p_rst;
    @(posedge clock) disable iff (!nrst)
    (ce && reset_request) |=> !peripheral_reset_n;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset output not asserted");

  property p_ready_release;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == STROBE && host_read && peripheral_wait_n) |=> iochrdy;
  endproperty
  a_ready_release: assert property (p_ready_release)
    else $error("ready not released after wait");

  property p_idle_ready;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == IDLE && !host_read) |=> iochrdy;
  endproperty
  a_idle_ready: assert property (p_idle_ready)
    else $error("ready low outside a cycle");

  // after an abort the strobes must stay off until the host lets go
  property p_done_hold;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == DONE) |=> (data_strobe_n && addr_strobe_n && iochrdy);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("strobe or wait state after abort");

  property p_dir_idle;
    @(posedge clock) disable iff (!nrst)
    (ce && state_r == IDLE && !host_read && !control_direction_bit) |=> !port_direction;
  endproperty
  a_dir_idle: assert property (p_dir_idle)
    else $error("direction high while idle");

  property p_wr_override;
    @(posedge clock) disable iff (!nrst)
    (ce && control_write_override) |=> !write_indicator_n;
  endproperty
  a_wr_override: assert property (p_wr_override)
    else $error("override did not assert write indicator");

  property p_rst_release;
    @(posedge clock) disable iff (!nrst)
    (ce && !reset_request && rcnt_r == 3'h0) |=> peripheral_reset_n;
  endproperty
  a_rst_release: assert property (p_rst_release)
    else $error("reset output stuck low");
endmodule
